/* wdg_pkg.sv */
`default_nettype none
// Shared constants and types for the window watchdog
package wdg_pkg;
  // Clock period
  localparam int CLK_PERIOD_NS    = 10;

  // Trigger low time must reach this before it counts
  localparam int TRIG_MIN_NS      = 200;
  localparam int TRIG_MIN_CYC     = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_CNT_W       = 5;

  // Fixed reset pulse length, power-up and watchdog alike
  localparam int RESET_MS         = 4;
  localparam int RESET_CYC        = RESET_MS * (1000000 / CLK_PERIOD_NS);
  localparam int RESET_CNT_W      = 19;

  // Phase lengths in oscillator periods
  localparam int LEAD_TICKS       = 7895;
  localparam int CLOSED_TICKS     = 1053;
  localparam int OPEN_TICKS       = 1105;
  localparam int TICK_CNT_W       = 13;

  // Fallback oscillator period when the timing resistor fails
  localparam int FALLBACK_NS      = 10000;
  localparam int FALLBACK_CYC     = FALLBACK_NS / CLK_PERIOD_NS;
  localparam int FALLBACK_CNT_W   = 10;

  // Synchroniser layout and idle levels
  localparam int SYNC_W           = 4;
  localparam int SYNC_TRIG        = 3;
  localparam int SYNC_OSC         = 2;
  localparam int SYNC_FAULT       = 1;
  localparam int SYNC_UV          = 0;
  localparam logic [SYNC_W-1:0] SYNC_INIT = 4'h8;

  // Watchdog sequence states
  typedef enum logic [2:0] {
    ST_RESET,
    ST_LEAD,
    ST_CLOSED,
    ST_OPEN,
    ST_OFF
  } wdg_state_t;
endpackage : wdg_pkg
`default_nettype wire

/* wdg_tb_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Timebase tick and fallback status toward the sequencer
interface wdg_tb_if;
  logic tick;
  logic fallback;

  modport src (output tick, output fallback);
  modport snk (input  tick, input  fallback);
endinterface : wdg_tb_if
`default_nettype wire

/* wdg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output follows once stages two and three agree
module wdg_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  din,
  output var  logic [W-1:0]  dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Agreement filter per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule : wdg_sync
`default_nettype wire

/* wdg_timebase.sv */
`timescale 1ns/1ps
`default_nettype none
// Oscillator tick source with internal fallback divider
module wdg_timebase #(
  parameter int FALLBACK_CYC = wdg_pkg::FALLBACK_CYC
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  osc_lvl,
  input  wire logic  fault_lvl,
  wdg_tb_if.src      tb
);
  localparam int CW = wdg_pkg::FALLBACK_CNT_W;

  logic          osc_q;
  logic [CW-1:0] div_cnt;
  logic          div_wrap;

  assign div_wrap = (div_cnt == CW'(FALLBACK_CYC - 1));

  // Fallback divider, free running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (div_wrap) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Tick on oscillator rise, or on divider wrap under fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q       <= 1'b0;
      tb.tick     <= 1'b0;
      tb.fallback <= 1'b0;
    end else begin
      osc_q       <= osc_lvl;
      tb.fallback <= fault_lvl;
      tb.tick     <= fault_lvl ? div_wrap : (osc_lvl && !osc_q);
    end
  end
endmodule : wdg_timebase
`default_nettype wire

/* wdg_window_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_window_watchdog #(
  parameter int RESET_CYC    = wdg_pkg::RESET_CYC,
  parameter int LEAD_TICKS   = wdg_pkg::LEAD_TICKS,
  parameter int CLOSED_TICKS = wdg_pkg::CLOSED_TICKS,
  parameter int OPEN_TICKS   = wdg_pkg::OPEN_TICKS,
  parameter int FALLBACK_CYC = wdg_pkg::FALLBACK_CYC
) (
  input  wire logic  CLOCK,
  input  wire logic  RST_N,
  input  wire logic  TRIGGER_IN_N,
  input  wire logic  TIMEBASE_OSC,
  input  wire logic  TIMEBASE_RESISTOR_PIN_FAULT,
  input  wire logic  UNDERVOLTAGE,
  input  wire logic  WATCHDOG_OFF_MODE,
  input  wire logic  NORMAL_MODE,
  input  wire logic  RXD_WAKE_N,
  output var  logic  RESET_OUT_N,
  output var  logic  FAILSAFE_REQ,
  output var  logic  FALLBACK_ACTIVE
);
  localparam int TW = wdg_pkg::TICK_CNT_W;
  localparam int RW = wdg_pkg::RESET_CNT_W;
  localparam int LW = wdg_pkg::TRIG_CNT_W;

  // Local names for the sequence states
  localparam wdg_pkg::wdg_state_t ST_RESET  = wdg_pkg::ST_RESET;
  localparam wdg_pkg::wdg_state_t ST_LEAD   = wdg_pkg::ST_LEAD;
  localparam wdg_pkg::wdg_state_t ST_CLOSED = wdg_pkg::ST_CLOSED;
  localparam wdg_pkg::wdg_state_t ST_OPEN   = wdg_pkg::ST_OPEN;
  localparam wdg_pkg::wdg_state_t ST_OFF    = wdg_pkg::ST_OFF;

  wdg_pkg::wdg_state_t       state;
  wdg_pkg::wdg_state_t       next_state;
  logic [wdg_pkg::SYNC_W-1:0] sync_out;
  logic                      trig_f;
  logic                      uv_f;
  logic [LW-1:0]             low_cnt;
  logic                      trig_valid;
  logic [TW-1:0]             tick_cnt;
  logic [RW-1:0]             rst_cnt;
  logic                      rst_last;
  logic                      wd_off_q;
  logic                      wd_off_rise;
  logic                      wd_off_fall;
  logic                      rxd_q;
  logic                      rxd_fall;
  logic                      lead_end;
  logic                      closed_end;
  logic                      open_end;

  wdg_tb_if tb ();

  // True on the tick that completes a phase of given length
  function automatic logic is_last(input logic [TW-1:0] cnt, input int len);
    is_last = (cnt == TW'(len - 1));
  endfunction : is_last

  // Pin inputs from outside the clock domain
  wdg_sync #(
    .W    (wdg_pkg::SYNC_W),
    .INIT (wdg_pkg::SYNC_INIT)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .din   ({TRIGGER_IN_N, TIMEBASE_OSC, TIMEBASE_RESISTOR_PIN_FAULT, UNDERVOLTAGE}),
    .dout  (sync_out)
  );

  // Oscillator tick, with fallback source
  wdg_timebase #(
    .FALLBACK_CYC (FALLBACK_CYC)
  ) u_timebase (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .osc_lvl   (sync_out[wdg_pkg::SYNC_OSC]),
    .fault_lvl (sync_out[wdg_pkg::SYNC_FAULT]),
    .tb        (tb.src)
  );

  assign trig_f = sync_out[wdg_pkg::SYNC_TRIG];
  assign uv_f   = sync_out[wdg_pkg::SYNC_UV];

  // Trigger low-time counter, saturating
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt <= '0;
    end else if (trig_f) begin
      low_cnt <= '0;
    end else if (low_cnt != LW'(wdg_pkg::TRIG_MIN_CYC)) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // One pulse per falling edge that stays low long enough
  assign trig_valid = !trig_f && (low_cnt == LW'(wdg_pkg::TRIG_MIN_CYC - 1));

  // Mode and wake edge detection
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wd_off_q <= 1'b0;
      rxd_q    <= 1'b1;
    end else begin
      wd_off_q <= WATCHDOG_OFF_MODE;
      rxd_q    <= RXD_WAKE_N;
    end
  end

  assign wd_off_rise = WATCHDOG_OFF_MODE && !wd_off_q;
  assign wd_off_fall = !WATCHDOG_OFF_MODE && wd_off_q;
  assign rxd_fall    = !RXD_WAKE_N && rxd_q;

  // Phase end decodes
  assign lead_end   = tb.tick && is_last(tick_cnt, LEAD_TICKS);
  assign closed_end = tb.tick && is_last(tick_cnt, CLOSED_TICKS);
  assign open_end   = tb.tick && is_last(tick_cnt, OPEN_TICKS);
  assign rst_last   = !uv_f && (rst_cnt == RW'(RESET_CYC - 1));

  // Sequence next state
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (rst_last) begin
          next_state = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (trig_valid) begin
          next_state = ST_CLOSED;
        end else if (lead_end) begin
          next_state = ST_RESET;
        end
      end
      ST_CLOSED: begin
        if (trig_valid) begin
          next_state = ST_RESET;
        end else if (closed_end) begin
          next_state = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (trig_valid) begin
          next_state = ST_CLOSED;
        end else if (open_end) begin
          next_state = ST_RESET;
        end
      end
      ST_OFF: begin
        if (rxd_fall || wd_off_fall) begin
          next_state = ST_LEAD;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    // Undervoltage first, then entry into the quiet mode
    if (uv_f) begin
      next_state = ST_RESET;
    end else if (wd_off_rise) begin
      next_state = ST_OFF;
    end
  end

  // State register; power-up starts in the reset hold
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Oscillator period counter, cleared on every phase change
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt <= '0;
    end else if (next_state != state) begin
      tick_cnt <= '0;
    end else if (tb.tick) begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Reset length counter in clock cycles, held at zero under undervoltage
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_cnt <= '0;
    end else if (state != ST_RESET || uv_f) begin
      rst_cnt <= '0;
    end else if (!rst_last) begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  // Reset output, low exactly while in the reset hold
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RESET_OUT_N <= 1'b0;
    end else begin
      RESET_OUT_N <= (next_state != ST_RESET);
    end
  end

  // Fail-safe request pulse and fallback status
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FAILSAFE_REQ    <= 1'b0;
      FALLBACK_ACTIVE <= 1'b0;
    end else begin
      FAILSAFE_REQ    <= NORMAL_MODE && (next_state == ST_RESET)
                         && (state != ST_RESET);
      FALLBACK_ACTIVE <= tb.fallback;
    end
  end

  // Checks on the sequence
  property p_lead_trig;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_LEAD) && trig_valid && !uv_f && !wd_off_rise
      |=> (state == ST_CLOSED) && (tick_cnt == '0) && RESET_OUT_N;
  endproperty
  a_lead_trig: assert property (p_lead_trig)
    else $error("lead trigger did not open closed window");

  property p_closed_trig;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_CLOSED) && trig_valid && !wd_off_rise |=> !RESET_OUT_N;
  endproperty
  a_closed_trig: assert property (p_closed_trig)
    else $error("closed window trigger did not reset");

  property p_open_trig;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_OPEN) && trig_valid && !uv_f && !wd_off_rise
      |=> (state == ST_CLOSED) && RESET_OUT_N;
  endproperty
  a_open_trig: assert property (p_open_trig)
    else $error("open window trigger did not restart");

  property p_lead_expire;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_LEAD) && tb.tick && (tick_cnt == TW'(LEAD_TICKS - 1))
      && !trig_valid && !wd_off_rise |=> !RESET_OUT_N && (rst_cnt == '0);
  endproperty
  a_lead_expire: assert property (p_lead_expire)
    else $error("lead timeout did not reset");

  property p_open_expire;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_OPEN) && tb.tick && (tick_cnt == TW'(OPEN_TICKS - 1))
      && !trig_valid && !wd_off_rise |=> !RESET_OUT_N;
  endproperty
  a_open_expire: assert property (p_open_expire)
    else $error("open window timeout did not reset");

  property p_closed_to_open;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_CLOSED) && tb.tick && (tick_cnt == TW'(CLOSED_TICKS - 1))
      && !trig_valid && !uv_f && !wd_off_rise |=> (state == ST_OPEN);
  endproperty
  a_closed_to_open: assert property (p_closed_to_open)
    else $error("closed window length wrong");

  property p_release_len;
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(RESET_OUT_N) && $past(state == ST_RESET)
      |-> (state == ST_LEAD) && ($past(rst_cnt) == RW'(RESET_CYC - 1));
  endproperty
  a_release_len: assert property (p_release_len)
    else $error("reset released early or not into lead time");

  property p_uv_reset;
    @(posedge CLOCK) disable iff (!RST_N)
    uv_f |=> !RESET_OUT_N;
  endproperty
  a_uv_reset: assert property (p_uv_reset)
    else $error("undervoltage did not hold reset");

  property p_off_quiet;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_OFF) && !uv_f && !rxd_fall && !wd_off_fall
      |=> (state == ST_OFF) && RESET_OUT_N;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("watchdog active in quiet mode");

  property p_hold_ignores;
    @(posedge CLOCK) disable iff (!RST_N)
    (state == ST_RESET) && !rst_last && !wd_off_rise |=> !RESET_OUT_N;
  endproperty
  a_hold_ignores: assert property (p_hold_ignores)
    else $error("reset hold ended early");

  property p_failsafe;
    @(posedge CLOCK) disable iff (!RST_N)
    $fell(RESET_OUT_N) && $past(NORMAL_MODE) |-> FAILSAFE_REQ;
  endproperty
  a_failsafe: assert property (p_failsafe)
    else $error("no fail-safe request on reset in normal mode");

  property p_edge_fresh;
    @(posedge CLOCK) disable iff (!RST_N)
    $fell(trig_f) |-> !trig_valid ##1 !trig_valid;
  endproperty
  a_edge_fresh: assert property (p_edge_fresh)
    else $error("trigger accepted without minimum low time");

  // Main scenarios
  c_open_service: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (state == ST_OPEN) && trig_valid ##1 (state == ST_CLOSED));
  c_closed_violation: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (state == ST_CLOSED) && trig_valid ##1 !RESET_OUT_N);
  c_lead_timeout: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (state == ST_LEAD) && lead_end ##1 (state == ST_RESET));
  c_wake: cover property (@(posedge CLOCK) disable iff (!RST_N)
    (state == ST_OFF) && rxd_fall ##1 (state == ST_LEAD));
endmodule : wdg_window_watchdog
`default_nettype wire

/* wdg_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host controller beside the watchdog: sends trigger pulses, takes resets
module wdg_mcu_model (
  input  wire logic clk,
  input  wire logic reset_n,
  output var  logic trig_n
);
  int resets_seen = 0;

  // Trigger line idles high between pulses
  initial trig_n = 1'b1;

  // Count reset pulses handed to the host
  always @(negedge reset_n) resets_seen++;

  // One trigger pulse, low for low_cyc clocks, then back high
  task automatic trigger(input int low_cyc);
    @(posedge clk);
    #1 trig_n = 1'b0;
    repeat (low_cyc) @(posedge clk);
    #1 trig_n = 1'b1;
  endtask : trigger
endmodule : wdg_mcu_model
`default_nettype wire

/* window_watchdog_reset_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %0t %s", $time, msg); end end
module window_watchdog_reset_bench;
  localparam int RST_CYC  = 50;
  localparam int LEAD     = 40;
  localparam int CLS      = 10;
  localparam int OPN      = 12;
  localparam int FBK      = 8;
  localparam int OSC_HALF = 10;
  localparam int LEAD_CYC = LEAD * 2 * OSC_HALF;
  localparam int WIN_CYC  = (CLS + OPN) * 2 * OSC_HALF;

  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic TRIGGER_IN_N;
  logic TIMEBASE_OSC = 1'b0;
  logic UNDERVOLTAGE = 1'b0;
  logic WATCHDOG_OFF_MODE = 1'b0;
  logic NORMAL_MODE = 1'b1;
  logic RXD_WAKE_N = 1'b1;
  logic RESET_OUT_N;
  logic FAILSAFE_REQ;
  logic FALLBACK_ACTIVE;
  logic osc_run = 1'b1;
  int   fs_cnt = 0;
  int   err_total = 0;
  int   checks = 0;

  wdg_window_watchdog #(.RESET_CYC(RST_CYC), .LEAD_TICKS(LEAD), .CLOSED_TICKS(CLS),
    .OPEN_TICKS(OPN), .FALLBACK_CYC(FBK)) DUT (
    .CLOCK(CLOCK), .RST_N(RST_N), .TRIGGER_IN_N(TRIGGER_IN_N),
    .TIMEBASE_OSC(TIMEBASE_OSC), .TIMEBASE_RESISTOR_PIN_FAULT(!osc_run),
    .UNDERVOLTAGE(UNDERVOLTAGE), .WATCHDOG_OFF_MODE(WATCHDOG_OFF_MODE),
    .NORMAL_MODE(NORMAL_MODE), .RXD_WAKE_N(RXD_WAKE_N), .RESET_OUT_N(RESET_OUT_N),
    .FAILSAFE_REQ(FAILSAFE_REQ), .FALLBACK_ACTIVE(FALLBACK_ACTIVE));

  wdg_mcu_model mcu (.clk(CLOCK), .reset_n(RESET_OUT_N), .trig_n(TRIGGER_IN_N));

  // Clock and resistor oscillator
  always #5 CLOCK = ~CLOCK;
  always begin
    repeat (OSC_HALF) @(posedge CLOCK);
    #1 TIMEBASE_OSC = osc_run & ~TIMEBASE_OSC;
  end

  // Fail-safe request pulses
  always @(posedge CLOCK) if (FAILSAFE_REQ === 1'b1) fs_cnt++;

  task automatic step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : step

  // Cycles until reset output reaches lvl, max_c+1 on timeout
  task automatic wait_rst(input logic lvl, input int max_c, output int n);
    n = 0;
    while (RESET_OUT_N !== lvl && n <= max_c) begin
      step(1);
      n++;
    end
  endtask : wait_rst

  task automatic t_powerup;
    int n;
    wait_rst(1'b1, 200, n);
    `CHK(n inside {[RST_CYC-1:RST_CYC+2]}, 1'b1, "power-up reset length")
    `CHK(FALLBACK_ACTIVE, 1'b0, "no fallback")
  endtask : t_powerup

  task automatic t_lead_timeout;
    int n, f0, r0;
    f0 = fs_cnt;
    r0 = mcu.resets_seen;
    wait_rst(1'b0, 1000, n);
    `CHK(n inside {[LEAD_CYC-40:LEAD_CYC+30]}, 1'b1, "lead timeout")
    wait_rst(1'b1, 200, n);
    `CHK(n, RST_CYC, "watchdog reset length")
    `CHK(fs_cnt, f0 + 1, "fail-safe pulse")
    `CHK(mcu.resets_seen, r0 + 1, "host saw reset")
  endtask : t_lead_timeout

  task automatic t_good_cycle;
    int r0;
    r0 = mcu.resets_seen;
    step(600); // Late service, still inside the lead time
    mcu.trigger(30);
    `CHK(RESET_OUT_N, 1'b1, "lead trigger accepted")
    repeat (3) begin
      step(270); // pin period near 300 cycles
      mcu.trigger(30);
      `CHK(RESET_OUT_N, 1'b1, "open window trigger")
    end
    `CHK(mcu.resets_seen, r0, "no reset while serviced")
  endtask : t_good_cycle

  task automatic t_closed_glitch;
    int n;
    step(50);
    mcu.trigger(5);
    step(30);
    `CHK(RESET_OUT_N, 1'b1, "short pulse ignored")
    step(10);
    mcu.trigger(30);
    `CHK(RESET_OUT_N, 1'b0, "closed window trigger")
    step(10); // Pin back high long enough to pass the filter
    mcu.trigger(30);
    wait_rst(1'b1, 200, n);
    wait_rst(1'b0, 1000, n);
    `CHK(n inside {[LEAD_CYC-40:LEAD_CYC+30]}, 1'b1, "trigger in reset ignored")
    wait_rst(1'b1, 200, n);
  endtask : t_closed_glitch

  task automatic t_open_timeout;
    int n, f0;
    NORMAL_MODE = 1'b0;
    f0 = fs_cnt;
    mcu.trigger(30);
    wait_rst(1'b0, 600, n);
    `CHK(n inside {[WIN_CYC-40:WIN_CYC]}, 1'b1, "open window timeout")
    wait_rst(1'b1, 200, n);
    `CHK(fs_cnt, f0, "no fail-safe outside normal mode")
    NORMAL_MODE = 1'b1;
  endtask : t_open_timeout

  task automatic t_off_mode;
    int n;
    WATCHDOG_OFF_MODE = 1'b1;
    step(5);
    repeat (4) begin
      mcu.trigger(30);
      step(20);
    end
    wait_rst(1'b0, 1000, n);
    `CHK(n, 1001, "off mode silent")
    RXD_WAKE_N = 1'b0;
    wait_rst(1'b0, 1000, n);
    `CHK(n inside {[LEAD_CYC-40:LEAD_CYC+30]}, 1'b1, "lead after wake")
    RXD_WAKE_N = 1'b1;
    WATCHDOG_OFF_MODE = 1'b0;
    wait_rst(1'b1, 200, n);
    // Leave the quiet mode by dropping the mode level
    WATCHDOG_OFF_MODE = 1'b1;
    step(50);
    WATCHDOG_OFF_MODE = 1'b0;
    wait_rst(1'b0, 1000, n);
    `CHK(n inside {[LEAD_CYC-40:LEAD_CYC+30]}, 1'b1, "lead after mode drop")
    wait_rst(1'b1, 200, n);
  endtask : t_off_mode

  task automatic t_undervoltage;
    int n;
    step(20);
    UNDERVOLTAGE = 1'b1;
    wait_rst(1'b0, 8, n);
    `CHK(n inside {[1:7]}, 1'b1, "undervoltage reset")
    step(100);
    `CHK(RESET_OUT_N, 1'b0, "held while undervoltage")
    UNDERVOLTAGE = 1'b0;
    wait_rst(1'b1, 200, n);
    `CHK(n inside {[RST_CYC:RST_CYC+7]}, 1'b1, "release after undervoltage")
  endtask : t_undervoltage

  task automatic t_fallback;
    int n;
    osc_run = 1'b0;
    step(10);
    `CHK(FALLBACK_ACTIVE, 1'b1, "fallback selected")
    wait_rst(1'b0, 1000, n);
    `CHK(n inside {[LEAD*FBK-30:LEAD*FBK+10]}, 1'b1, "fallback lead")
    wait_rst(1'b1, 200, n);
  endtask : t_fallback

  task automatic final_report;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    step(6);
    RST_N = 1'b1;
    t_powerup();
    t_lead_timeout();
    t_good_cycle();
    t_closed_glitch();
    t_open_timeout();
    t_off_mode();
    t_undervoltage();
    t_fallback();
    final_report();
  end

  // Hang guard
  initial begin
    #500000;
    err_total++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end
endmodule : window_watchdog_reset_bench
`default_nettype wire
